// ==== hw/hpb_port.sv ====
// Parallel microprocessor port: strobe decode, address latch, irq and reset
`timescale 1ns/1ns
module hpb_port
  import hpb_pkg::*;
#(
  parameter int HOLD_CYC = RST_HOLD_CYC
) (
  // Clock, reset, enable
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic              ce,
  // Host bus pins
  input  wire logic              cs_n,
  input  wire logic              wr_rw,
  input  wire logic              data_strobe_n,
  input  wire logic              ale,
  input  wire logic              bus_mode,
  input  wire logic [ADDR_W-1:0] host_addr_bus,
  input  wire logic [DATA_W-1:0] host_data_bus_in,
  output logic      [DATA_W-1:0] host_data_bus_out,
  output logic                   host_data_bus_oe,
  // Interrupt and reset pins
  input  wire logic              interrupt_ack_in,
  input  wire logic              sys_reset_in,
  output logic                   interrupt_out,
  output logic                   interrupt_oe,
  output logic                   reset_active_out,
  // Register side of the device
  output logic      [ADDR_W-1:0] reg_addr,
  output logic      [DATA_W-1:0] reg_wdata,
  output logic                   reg_wr,
  output logic                   reg_rd,
  input  wire logic [DATA_W-1:0] reg_rdata,
  // Interrupt source and its configuration
  input  wire logic              irq_pending,
  input  wire logic              irq_open_drain,
  input  wire logic              irq_active_high,
  output logic                   irq_ack
);

  // Synchronised pins
  logic [SYNC_W-1:0] pins_s;
  logic              cs_s;
  logic              wr_s;
  logic              stb_s;
  logic              ale_s;
  logic              mode_s;
  logic              ack_s;
  logic              rst_s;
  logic [ADDR_W-1:0] addr_s;
  logic [DATA_W-1:0] data_s;
  logic              dev_rst;
  logic [1:0]        acc;

  // Every pin crosses two flops before use
  hpb_sync #(
    .WIDTH (SYNC_W)
  ) u_sync (
    .clk      (clk),
    .rstn     (rstn),
    .ce       (ce),
    .async_in ({host_data_bus_in, host_addr_bus, sys_reset_in, interrupt_ack_in,
                bus_mode, ale, data_strobe_n, wr_rw, cs_n}),
    .sync_out (pins_s)
  );

  // Field split of the synchronised vector
  assign cs_s   = pins_s[PIN_CS];
  assign wr_s   = pins_s[PIN_WR];
  assign stb_s  = pins_s[PIN_STB];
  assign ale_s  = pins_s[PIN_ALE];
  assign mode_s = pins_s[PIN_MODE];
  assign ack_s  = pins_s[PIN_ACK];
  assign rst_s  = pins_s[PIN_RST];
  assign addr_s = pins_s[ADDR_LSB +: ADDR_W];
  assign data_s = pins_s[DATA_LSB +: DATA_W];

  // Reset indication; the port stays in reset while it is active
  hpb_rst_ind #(
    .HOLD_CYC (HOLD_CYC)
  ) u_rst_ind (
    .clk     (clk),
    .rstn    (rstn),
    .ce      (ce),
    .rst_req (rst_s),
    .active  (dev_rst)
  );

  assign reset_active_out = dev_rst;

  // Strobe decode for the selected protocol
  assign acc = hpb_access(cs_s, mode_s, wr_s, stb_s);

  // ---- Bus mode and address latch ----
  logic              ale_d_reg;
  logic              ale_d_next;
  logic              mux_reg;
  logic              mux_next;
  logic              mux_init_reg;
  logic              mux_init_next;
  logic [ADDR_W-1:0] addr_latch_reg;
  logic [ADDR_W-1:0] addr_latch_next;
  logic [ADDR_W-1:0] addr_cur;

  // Bus mode taken from the latch-enable level once reset ends; any
  // falling edge later also means multiplexed, since a tied pin never falls
  always_comb begin
    ale_d_next      = ale_d_reg;
    mux_next        = mux_reg;
    mux_init_next   = mux_init_reg;
    addr_latch_next = addr_latch_reg;
    if (ce) begin
      ale_d_next = ale_s;
      if (dev_rst) begin
        mux_init_next = 1'b0;
      end else if (!mux_init_reg) begin
        mux_init_next = 1'b1;
        mux_next      = (ale_s == BUS_MUX_ALE);
      end else if (ale_d_reg && !ale_s) begin
        mux_next = 1'b1;
      end
      // Transparent while high, so the falling edge leaves the last address
      if (ale_s) begin
        addr_latch_next = data_s[ADDR_W-1:0];
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ale_d_reg      <= 1'b0;
      mux_reg        <= 1'b0;
      mux_init_reg   <= 1'b0;
      addr_latch_reg <= '0;
    end else begin
      ale_d_reg      <= ale_d_next;
      mux_reg        <= mux_next;
      mux_init_reg   <= mux_init_next;
      addr_latch_reg <= addr_latch_next;
    end
  end

  // Seven-bit address from the latch or the separate address pins
  assign addr_cur = mux_reg ? addr_latch_reg : addr_s;

  // ---- Access state machine ----
  hpb_state_t        state_reg;
  hpb_state_t        state_next;
  logic [ADDR_W-1:0] addr_reg;
  logic [ADDR_W-1:0] addr_next;
  logic [DATA_W-1:0] wdata_reg;
  logic [DATA_W-1:0] wdata_next;
  logic [DATA_W-1:0] dout_reg;
  logic [DATA_W-1:0] dout_next;
  logic              oe_reg;
  logic              oe_next;
  logic              wr_reg;
  logic              wr_next;
  logic              rd_reg;
  logic              rd_next;

  // One request pulse per access: read at its start, write at its end,
  // so the data sampled last before the strobe rises is the one stored
  always_comb begin
    state_next = state_reg;
    addr_next  = addr_reg;
    wdata_next = wdata_reg;
    dout_next  = dout_reg;
    oe_next    = oe_reg;
    wr_next    = wr_reg;
    rd_next    = rd_reg;
    if (ce) begin
      wr_next = 1'b0;
      rd_next = 1'b0;
      if (dev_rst) begin
        state_next = HPB_IDLE;
        oe_next    = 1'b0;
      end else begin
        unique case (state_reg)
          HPB_IDLE: begin
            oe_next = 1'b0;
            if (acc == ACC_RD) begin
              state_next = HPB_READ;
              addr_next  = addr_cur;
              rd_next    = 1'b1;
            end else if (acc == ACC_WR) begin
              state_next = HPB_WRITE;
              addr_next  = addr_cur;
              wdata_next = data_s;
            end
          end
          HPB_READ: begin
            if (acc == ACC_RD) begin
              oe_next   = 1'b1;
              dout_next = reg_rdata;
            end else begin
              state_next = HPB_IDLE;
              oe_next    = 1'b0;
            end
          end
          HPB_WRITE: begin
            if (acc == ACC_WR) begin
              wdata_next = data_s;
            end else begin
              state_next = HPB_IDLE;
              wr_next    = 1'b1;
            end
          end
          default: begin
            state_next = HPB_IDLE;
            oe_next    = 1'b0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= HPB_IDLE;
      addr_reg  <= '0;
      wdata_reg <= '0;
      dout_reg  <= '0;
      oe_reg    <= 1'b0;
      wr_reg    <= 1'b0;
      rd_reg    <= 1'b0;
    end else begin
      state_reg <= state_next;
      addr_reg  <= addr_next;
      wdata_reg <= wdata_next;
      dout_reg  <= dout_next;
      oe_reg    <= oe_next;
      wr_reg    <= wr_next;
      rd_reg    <= rd_next;
    end
  end

  // Register outputs
  assign reg_addr          = addr_reg;
  assign reg_wdata         = wdata_reg;
  assign reg_wr            = wr_reg;
  assign reg_rd            = rd_reg;
  assign host_data_bus_out = dout_reg;
  assign host_data_bus_oe  = oe_reg;

  // ---- Interrupt pin and acknowledge ----
  logic irq_o_reg;
  logic irq_o_next;
  logic irq_oe_reg;
  logic irq_oe_next;
  logic ack_d_reg;
  logic ack_d_next;
  logic ack_reg;
  logic ack_next;

  // Open-drain never drives high so a shared line stays wired-low;
  // pin held floating during reset
  always_comb begin
    irq_o_next  = irq_o_reg;
    irq_oe_next = irq_oe_reg;
    ack_d_next  = ack_d_reg;
    ack_next    = ack_reg;
    if (ce) begin
      ack_d_next  = ack_s;
      ack_next    = !dev_rst && !ack_d_reg && ack_s; // Rising edge of the ack pin
      if (dev_rst) begin
        irq_o_next  = 1'b0;
        irq_oe_next = 1'b0;
      end else if (irq_open_drain) begin
        irq_o_next  = 1'b0;
        irq_oe_next = irq_pending;
      end else begin
        irq_o_next  = (irq_pending == irq_active_high);
        irq_oe_next = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_o_reg  <= 1'b0;
      irq_oe_reg <= 1'b0;
      ack_d_reg  <= 1'b0;
      ack_reg    <= 1'b0;
    end else begin
      irq_o_reg  <= irq_o_next;
      irq_oe_reg <= irq_oe_next;
      ack_d_reg  <= ack_d_next;
      ack_reg    <= ack_next;
    end
  end

  assign interrupt_out = irq_o_reg;
  assign interrupt_oe  = irq_oe_reg;
  assign irq_ack       = ack_reg;

  // ---- Checks ----
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_read_start : assert property (
    ce && !dev_rst && state_reg == HPB_IDLE && acc == ACC_RD
      |=> reg_rd && state_reg == HPB_READ && reg_addr == $past(addr_cur))
    else $error("read access not started");

  a_read_drive : assert property (
    ce && !dev_rst && state_reg == HPB_READ && acc == ACC_RD
      |=> host_data_bus_oe && host_data_bus_out == $past(reg_rdata))
    else $error("read data not driven");

  a_write_store : assert property (
    ce && !dev_rst && state_reg == HPB_WRITE && acc != ACC_WR
      |=> reg_wr && reg_wdata == $past(wdata_reg))
    else $error("write data not passed on");

  a_dir_write : assert property (
    ce && !dev_rst && state_reg == HPB_IDLE && !cs_s && mode_s && !stb_s && !wr_s
      |=> state_reg == HPB_WRITE ##1 !reg_rd)
    else $error("direction strobe write mis-decoded");

  a_bus_release : assert property (
    ce && cs_s |=> !host_data_bus_oe && !reg_rd)
    else $error("bus driven while deselected");

  a_latch_pass : assert property (
    ce && ale_s |=> addr_latch_reg == $past(data_s[ADDR_W-1:0]))
    else $error("address latch not transparent");

  a_latch_hold : assert property (
    ce && !ale_s |=> $stable(addr_latch_reg))
    else $error("address latch moved while closed");

  a_irq_open : assert property (
    ce && !dev_rst && irq_open_drain
      |=> !interrupt_out && interrupt_oe == $past(irq_pending))
    else $error("open-drain interrupt drove high");

  a_irq_push : assert property (
    ce && !dev_rst && !irq_open_drain
      |=> interrupt_oe && interrupt_out == ($past(irq_pending) == $past(irq_active_high)))
    else $error("push-pull interrupt level wrong");

  a_reset_quiet : assert property (
    ce && dev_rst |=> state_reg == HPB_IDLE && !host_data_bus_oe && !interrupt_oe)
    else $error("port active during reset");

  c_read : cover property (reg_rd ##[1:8] host_data_bus_oe);
  c_write : cover property (state_reg == HPB_WRITE ##[1:20] reg_wr);
  c_mux : cover property (mux_reg && $fell(ale_s));
  c_reset_end : cover property ($fell(reset_active_out));

endmodule : hpb_port

// ==== hw/hpb_pkg.sv ====
// Constants, types and decode helpers shared by the parallel host port
package hpb_pkg;

  // Bus widths
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;

  // Reset indication hold time and its cycle count (least time, rounds up)
  localparam int CLK_MHZ       = 100;
  localparam int RST_HOLD_US   = 500;
  localparam int RST_HOLD_CYC  = RST_HOLD_US * CLK_MHZ;
  localparam int RST_CNT_W     = 17;

  // Field positions in the synchronised pin vector
  localparam int PIN_CS    = 0;
  localparam int PIN_WR    = 1;
  localparam int PIN_STB   = 2;
  localparam int PIN_ALE   = 3;
  localparam int PIN_MODE  = 4;
  localparam int PIN_ACK   = 5;
  localparam int PIN_RST   = 6;
  localparam int CTL_W     = 7;
  localparam int ADDR_LSB  = CTL_W;
  localparam int DATA_LSB  = CTL_W + ADDR_W;
  localparam int SYNC_W    = CTL_W + ADDR_W + DATA_W;

  // Pin levels with meaning
  localparam logic BUS_SEP_STROBE = 1'b0;
  localparam logic BUS_MUX_ALE    = 1'b0;

  // Access kinds seen on the strobes
  localparam logic [1:0] ACC_NONE = 2'h0;
  localparam logic [1:0] ACC_RD   = 2'h1;
  localparam logic [1:0] ACC_WR   = 2'h2;

  // Bus access states
  typedef enum logic [1:0] {
    HPB_IDLE  = 2'b00,
    HPB_READ  = 2'b01,
    HPB_WRITE = 2'b10
  } hpb_state_t;

  // Decode strobe levels into an access kind for either bus protocol
  function automatic logic [1:0] hpb_access(input logic cs_n, input logic mode,
                                             input logic wr_rw, input logic strobe_n);
    logic [1:0] kind;
    kind = ACC_NONE;
    if (!cs_n) begin
      if (mode == BUS_SEP_STROBE) begin
        // Both strobes low is not a legal cycle; ignore it
        if (!strobe_n && wr_rw) kind = ACC_RD;
        else if (strobe_n && !wr_rw) kind = ACC_WR;
      end else if (!strobe_n) begin
        kind = wr_rw ? ACC_RD : ACC_WR;
      end
    end
    return kind;
  endfunction : hpb_access

endpackage : hpb_pkg

// ==== hw/hpb_sync.sv ====
// Two-stage synchroniser for a vector of pin inputs
`timescale 1ns/1ns
module hpb_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             ce,
  // Asynchronous input and synchronised output
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] sync_next;

  // Next values; first stage only feeds the second
  always_comb begin
    meta_next = ce ? async_in : meta_reg;
    sync_next = ce ? meta_reg : sync_reg;
  end

  // Stage registers, cleared to zero
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg;
endmodule : hpb_sync

// ==== hw/hpb_rst_ind.sv ====
// Reset indication stretcher: active during reset and a hold time after
`timescale 1ns/1ns
module hpb_rst_ind
  import hpb_pkg::*;
#(
  parameter int HOLD_CYC = RST_HOLD_CYC
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic ce,
  // Synchronised reset request and indication
  input  wire logic rst_req,
  output logic      active
);
  logic [RST_CNT_W-1:0] cnt_reg;
  logic [RST_CNT_W-1:0] cnt_next;
  logic                 active_reg;
  logic                 active_next;

  // Reload while held, count down after release
  always_comb begin
    cnt_next    = cnt_reg;
    active_next = active_reg;
    if (ce) begin
      if (rst_req) begin
        cnt_next    = RST_CNT_W'(HOLD_CYC - 1);
        active_next = 1'b1;
      end else if (cnt_reg != '0) begin
        cnt_next = cnt_reg - 1'b1;
      end else begin
        active_next = 1'b0;
      end
    end
  end

  // Chip reset starts a full hold as well
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_reg    <= RST_CNT_W'(HOLD_CYC - 1);
      active_reg <= 1'b1;
    end else begin
      cnt_reg    <= cnt_next;
      active_reg <= active_next;
    end
  end

  assign active = active_reg;

  // Indication never drops while the hold count runs
  a_hold_count : assert property (@(posedge clk) disable iff (!rstn)
    (cnt_reg != '0) |-> active_reg)
    else $error("reset indication dropped before hold time ended");
endmodule : hpb_rst_ind

// ==== tb/hpb_host.sv ====
// Behavioural host processor model driving the parallel bus pins
`timescale 1ns/1ns
module hpb_host
  import hpb_pkg::*;
(
  // Clock
  input  wire logic              clk,
  // Bus pins towards the port
  output logic                   cs_n,
  output logic                   wr_rw,
  output logic                   data_strobe_n,
  output logic                   ale,
  output logic                   bus_mode,
  output logic      [ADDR_W-1:0] host_addr_bus,
  // Host side of the data wire and the resolved wire
  output logic                   h_drv,
  output logic      [DATA_W-1:0] h_d,
  input  wire logic [DATA_W-1:0] bus_w,
  input  wire logic              bus_oe
);
  // Idle bus; ale high means demultiplexed after reset
  initial begin
    cs_n = 1'b1;
    wr_rw = 1'b1;
    data_strobe_n = 1'b1;
    ale = 1'b1;
    bus_mode = 1'b0;
    host_addr_bus = '0;
    h_drv = 1'b0;
    h_d = '0;
  end

  // One whole access; mux sends the address on the data wire first
  task automatic acc(input logic m, input logic mx, input logic sel, input logic wr,
                     input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                     output logic [DATA_W-1:0] q, output logic seen, output logic rel);
    @(posedge clk);
    bus_mode      <= m;
    host_addr_bus <= mx ? ~a : a;  // Wrong pins in mux mode on purpose
    if (mx) begin
      h_drv <= 1'b1;
      h_d   <= {1'b0, a};
      ale   <= 1'b1;
      repeat (3) @(posedge clk);
      ale   <= 1'b0;
      repeat (3) @(posedge clk);
    end
    h_drv <= wr;
    h_d   <= d;
    repeat (2) @(posedge clk);
    // Strobes set together so no direction change shows mid-access
    cs_n          <= ~sel;
    wr_rw         <= ~wr;
    data_strobe_n <= (m == BUS_SEP_STROBE) ? wr : 1'b0;
    repeat (6) @(posedge clk);
    q    = bus_w;
    seen = bus_oe;
    cs_n          <= 1'b1;
    wr_rw         <= 1'b1;
    data_strobe_n <= 1'b1;
    // Data held past strobe end, as the capture needs
    repeat (5) @(posedge clk);
    rel   = bus_oe;
    h_drv <= 1'b0;
  endtask : acc
endmodule : hpb_host

// ==== tb/tb.sv ====
// Self-checking bench for the parallel host port
`timescale 1ns/1ns
module tb;
  import hpb_pkg::*;
  localparam int HOLD = 20;
  logic              clk, rstn, sys_reset_in, irq_ack, reset_active_out;
  logic              irq_pending, irq_open_drain, irq_active_high;
  logic              cs_n, wr_rw, data_strobe_n, ale, bus_mode, h_drv;
  logic              ce, ack_pin;
  logic              host_data_bus_oe, interrupt_out, interrupt_oe, reg_wr, reg_rd;
  logic [ADDR_W-1:0] host_addr_bus, reg_addr;
  logic [DATA_W-1:0] h_d, bus_w, host_data_bus_out, reg_wdata, reg_rdata, q, ex;
  logic [DATA_W-1:0] bus_last = '0;
  logic [DATA_W-1:0] rf [128];
  logic              seen, rel;
  int                n_fail, total_checks, cyc, n, n_rd, n_ack;

  // Clock at 100 MHz
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Wire level; a floating wire toggles so stale data cannot pass
  assign bus_w = host_data_bus_oe ? host_data_bus_out : (h_drv ? h_d : ~bus_last);
  always @(posedge clk) bus_last <= bus_w;

  // Register file answers combinationally, as the port expects
  assign reg_rdata = rf[reg_addr];
  always @(posedge clk) if (reg_wr) rf[reg_addr] <= reg_wdata;

  // Pulse counters for read requests and acknowledges
  always @(posedge clk) if (reg_rd) n_rd++;
  always @(posedge clk) if (irq_ack) n_ack++;

  hpb_port #(.HOLD_CYC(HOLD)) hpb_port_inst (
    .clk(clk), .rstn(rstn), .ce(ce),
    .cs_n(cs_n), .wr_rw(wr_rw), .data_strobe_n(data_strobe_n), .ale(ale),
    .bus_mode(bus_mode), .host_addr_bus(host_addr_bus), .host_data_bus_in(bus_w),
    .host_data_bus_out(host_data_bus_out), .host_data_bus_oe(host_data_bus_oe),
    .interrupt_ack_in(ack_pin), .sys_reset_in(sys_reset_in), .interrupt_out(interrupt_out),
    .interrupt_oe(interrupt_oe), .reset_active_out(reset_active_out),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq_pending(irq_pending), .irq_open_drain(irq_open_drain),
    .irq_active_high(irq_active_high), .irq_ack(irq_ack)
  );

  hpb_host hpb_host_inst (
    .clk(clk), .cs_n(cs_n), .wr_rw(wr_rw), .data_strobe_n(data_strobe_n), .ale(ale),
    .bus_mode(bus_mode), .host_addr_bus(host_addr_bus), .h_drv(h_drv), .h_d(h_d),
    .bus_w(bus_w), .bus_oe(host_data_bus_oe)
  );

  // Compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic give_verdict;
    if (n_fail == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict

  // Length of the reset indication, bounded wait
  task automatic hold_len;
    n = 0;
    @(posedge clk);
    while (reset_active_out !== 1'b0 && n < 200) begin
      @(posedge clk);
      n++;
    end
  endtask : hold_len

  // Write then read back one address
  task automatic do_rw(input logic m, input logic mx, input logic [6:0] a, input logic [7:0] d);
    hpb_host_inst.acc(m, mx, 1'b1, 1'b1, a, d, q, seen, rel);
    chk({7'h00, seen}, 8'h00);
    hpb_host_inst.acc(m, mx, 1'b1, 1'b0, a, 8'h00, q, seen, rel);
    chk(q, d);
    chk({6'h00, seen, rel}, 8'h02);
  endtask : do_rw

  // Hang guard, well above the expected run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      give_verdict();
    end
  end

  initial begin
    n_fail = 0;
    total_checks = 0;
    cyc = 0;
    n_rd = 0;
    n_ack = 0;
    ce = 1'b1;
    ack_pin = 1'b0;
    rstn = 1'b0;
    sys_reset_in = 1'b0;
    {irq_open_drain, irq_active_high, irq_pending} = 3'h0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    hold_len();
    chk({7'h00, n >= HOLD && n <= HOLD + 5}, 8'h01);
    repeat (2) @(posedge clk);
    // Both protocols, boundary addresses and one between
    for (int m = 0; m < 2; m++) begin
      do_rw(m[0], 1'b0, 7'h00, 8'hA5 + m[7:0]);
      do_rw(m[0], 1'b0, 7'h7F, 8'h5A + m[7:0]);
      do_rw(m[0], 1'b0, 7'h2A, 8'h3C + m[7:0]);
    end
    // Strobes without chip select are ignored
    hpb_host_inst.acc(1'b0, 1'b0, 1'b0, 1'b1, 7'h00, 8'hFF, q, seen, rel);
    hpb_host_inst.acc(1'b0, 1'b0, 1'b0, 1'b0, 7'h00, 8'h00, q, seen, rel);
    chk({7'h00, seen}, 8'h00);
    hpb_host_inst.acc(1'b0, 1'b0, 1'b1, 1'b0, 7'h00, 8'h00, q, seen, rel);
    chk(q, 8'hA6);
    // Every interrupt configuration and level
    for (int k = 0; k < 8; k++) begin
      @(posedge clk);
      {irq_open_drain, irq_active_high, irq_pending} <= k[2:0];
      repeat (3) @(posedge clk);
      ex = irq_open_drain ? {6'h00, irq_pending, 1'b0} : {6'h00, 1'b1, irq_pending == irq_active_high};
      chk({6'h00, interrupt_oe, interrupt_out}, ex);
    end
    // Clock enable low freezes the interrupt pin; an ack pin rise gives one pulse
    @(posedge clk);
    ce          <= 1'b0;
    irq_pending <= 1'b0;
    repeat (3) @(posedge clk);
    chk({6'h00, interrupt_oe, interrupt_out}, 8'h02);
    ce <= 1'b1;
    repeat (3) @(posedge clk);
    chk({6'h00, interrupt_oe, interrupt_out}, 8'h00);
    ack_pin <= 1'b1;
    repeat (5) @(posedge clk);
    chk(n_ack[7:0], 8'h01);
    ack_pin <= 1'b0;
    repeat (5) @(posedge clk);
    chk(n_ack[7:0], 8'h01);
    // System reset mid-run refuses a write and stretches the indication
    @(posedge clk);
    sys_reset_in <= 1'b1;
    hpb_host_inst.acc(1'b0, 1'b0, 1'b1, 1'b1, 7'h00, 8'h11, q, seen, rel);
    chk({6'h00, interrupt_oe, reset_active_out}, 8'h01);
    sys_reset_in <= 1'b0;
    hold_len();
    chk({7'h00, n >= HOLD && n <= HOLD + 5}, 8'h01);
    repeat (2) @(posedge clk);
    hpb_host_inst.acc(1'b0, 1'b0, 1'b1, 1'b0, 7'h00, 8'h00, q, seen, rel);
    chk(q, 8'hA6);
    // Multiplexed address and data on one wire, both protocols
    do_rw(1'b0, 1'b1, 7'h11, 8'h96);
    do_rw(1'b1, 1'b1, 7'h6E, 8'h69);
    // One read request per selected read outside reset, ten in all
    chk(n_rd[7:0], 8'h0A);
    give_verdict();
  end
endmodule : tb
